// ==== ccf_cfg.svh ====
`ifndef CCF_CFG_SVH
`define CCF_CFG_SVH
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CCF_HCLK_HZ 40000000
`define CCF_FIXED_HZ 8000000
`define CCF_FIXED_DIV (`CCF_HCLK_HZ / `CCF_FIXED_HZ)
`define CCF_DB_SAMPLES 4
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CCF_OFS_RELOAD 8'h00
`define CCF_OFS_CLKSEL 8'h30
`define CCF_OFS_MODE 8'h34
`define CCF_OFS_DEBOUNCE 8'h38
`define CCF_OFS_IRQ 8'h3C
`define CCF_OFS_STATUS 8'h40
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define CCF_CK1_SEL_BIT 20
`define CCF_IRQ_EN_LSB 0
`define CCF_IRQ_PEND_LSB 8
`define CCF_STAT_GATE_LSB 16
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CCF_RST_RELOAD 16'h0000
`define CCF_RST_CLKSEL 21'h00_0000
`define CCF_RST_MODE 12'h000
`define CCF_RST_DEBOUNCE 11'h000
`define CCF_RST_IRQ_EN 2'h0
`define CCF_RST_PINS 22'h00_FFC00
`endif

// ==== ccf_pkg.sv ====
package ccf_pkg;
    // clock source of one of counters 1 to 10
    typedef enum logic [1:0] {
        CCF_SRC_EXT = 2'h0,
        CCF_SRC_PREV = 2'h1,
        CCF_SRC_SHARED = 2'h2,
        CCF_SRC_C10 = 2'h3
    } ccf_src_t;

    // output style of one counter
    typedef enum logic {
        CCF_MODE_SQUARE = 1'h0,
        CCF_MODE_RATE = 1'h1
    } ccf_mode_t;

    // live state of one 16-bit down counter
    typedef struct packed {
        logic out;
        logic [15:0] count;
        logic [15:0] reload;
    } ccf_ctr_t;
endpackage

// ==== ccf_fabric.sv ====
`timescale 1ns/1ps
`include "ccf_cfg.svh"

// What this block does
// - twelve counters, three per group; 11 and 12 always chained, others free.
// - each counter has one clock, one gate, one output set by programming.
// - counter 11 runs off fixed 8 MHz; its output clocks counter 12.
// - gates of counters 11 and 12 are held permanently high.
// - counters 11 and 12 form a two-stage divider, square-wave unless their mode bits select rate.
// - counters 1 to 10 pick external, previous, shared or counter 10 clock.
// - shared internal clock is fixed 8 MHz or counter 11 output.
// - counter 1 set to previous counter gets a grounded clock.
// - gates of counters 1 to 10 idle high unless driven low.
// - all twelve counter outputs go straight to pins.
// - counter 12 output is the internal interrupt source.
// - each external clock and interrupt input may bypass or use debounce.
// - debounce output follows input only after four stable samples.
// - two independent pending interrupts, external and counter 12.
// - both pending interrupts merge onto one active-low interrupt line.
// - software reads pending status and clears it before next request.
// - each interrupt source has an enable; disabled ones never raise the line.
// - every counter is a 16-bit down counter.
module ccf_fabric
    import ccf_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [9:0] external_counter_clock,
    input wire logic [9:0] gate_in,
    input wire logic external_interrupt_input,
    input wire logic debounce_sample_clock,
    output logic [11:0] counter_output,
    output logic inta_n
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    ccf_ctr_t ctr [12];
    logic [21:0] pin_s1;
    logic [21:0] pin_s2;
    logic debounce_sample_clock_prev;
    logic db_strobe;
    logic [10:0] db_raw;
    logic [10:0] db_out;
    logic [1:0] db_cnt [11];
    logic [10:0] db_en;
    logic [10:0] filt;
    logic [2:0] fixed_div;
    logic fixed_lvl;
    logic shared_clk;
    logic [20:0] clk_sel;
    logic [11:0] mode;
    logic [11:0] clk_lvl;
    logic [11:0] clk_prev;
    logic [11:0] clk_edge;
    logic [11:0] gate;
    logic [1:0] irq_en;
    logic [1:0] irq_pend;
    logic ext_int_prev;
    logic c12_prev;
    logic [1:0] irq_event;
    logic [7:0] dp_addr;
    logic dp_write;
    logic [31:0] next_rdata;
    logic ap_take;

    // one tick of a counter; a reload of zero counts 65536 by wrap
    function automatic ccf_ctr_t ctr_step(ccf_ctr_t c, logic rate);
        ccf_ctr_t n;
        n = c;
        if (c.count == 16'h0001) begin
            n.count = c.reload;
            n.out = rate ? 1'b1 : ~c.out;
        end else begin
            n.count = c.count - 16'h0001;
            if (rate && c.count == 16'h0002) begin
                n.out = 1'b0;
            end
        end
        return n;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // gates reset high, as though the pull-ups hold them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_s1 <= `CCF_RST_PINS;
            pin_s2 <= `CCF_RST_PINS;
        end else begin
            pin_s1 <= {debounce_sample_clock, external_interrupt_input, gate_in,
                       external_counter_clock};
            pin_s2 <= pin_s1;
        end
    end

    assign db_raw = pin_s2[20] ? {1'b1, pin_s2[9:0]} : {1'b0, pin_s2[9:0]};
    assign db_strobe = pin_s2[21] & ~debounce_sample_clock_prev;

    // ------------------------------------------------------------
    // debounce filters
    // ------------------------------------------------------------
    // a sample that agrees with the output restarts the run
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            debounce_sample_clock_prev <= 1'b0;
            db_out <= 11'h000;
            for (int i = 0; i < 11; i++) begin
                db_cnt[i] <= 2'h0;
            end
        end else begin
            debounce_sample_clock_prev <= pin_s2[21];
            for (int i = 0; i < 11; i++) begin
                if (db_strobe) begin
                    if (db_raw[i] == db_out[i]) begin
                        db_cnt[i] <= 2'h0;
                    end else if (db_cnt[i] == 2'(`CCF_DB_SAMPLES - 1)) begin
                        db_out[i] <= db_raw[i];
                        db_cnt[i] <= 2'h0;
                    end else begin
                        db_cnt[i] <= db_cnt[i] + 2'h1;
                    end
                end
            end
        end
    end

    // static per-input bypass or filter
    assign filt = (db_en & db_out) | (~db_en & db_raw);

    // ------------------------------------------------------------
    // clock routing
    // ------------------------------------------------------------
    // fixed 8 MHz clock made from hclk; high for the first two of every five cycles
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fixed_div <= 3'h0;
            fixed_lvl <= 1'b0;
        end else begin
            if (fixed_div == 3'(`CCF_FIXED_DIV - 1)) begin
                fixed_div <= 3'h0;
            end else begin
                fixed_div <= fixed_div + 3'h1;
            end
            fixed_lvl <= (fixed_div < 3'(`CCF_FIXED_DIV / 2));
        end
    end

    // shared internal clock choice
    assign shared_clk = clk_sel[`CCF_CK1_SEL_BIT] ? counter_output[10] : fixed_lvl;

    // per-counter source mux; counter 1 has no predecessor
    always_comb begin
        for (int n = 0; n < 10; n++) begin
            case (ccf_src_t'(clk_sel[2*n +: 2]))
                CCF_SRC_EXT: clk_lvl[n] = filt[n];
                CCF_SRC_PREV: clk_lvl[n] = (n == 0) ? 1'b0 : counter_output[(n + 11) % 12];
                CCF_SRC_SHARED: clk_lvl[n] = shared_clk;
                CCF_SRC_C10: clk_lvl[n] = counter_output[9];
                default: clk_lvl[n] = 1'b0;
            endcase
        end
        clk_lvl[10] = fixed_lvl;
        clk_lvl[11] = counter_output[10];
    end

    // counters 11 and 12 always enabled
    assign gate = {2'b11, pin_s2[19:10]};
    assign clk_edge = clk_lvl & ~clk_prev;

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    // twelve 16-bit down counters, counting on rising clock edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // counter 12 clock is counter 11 output, high in reset: no false edge
            clk_prev <= 12'h800;
            for (int i = 0; i < 12; i++) begin
                ctr[i] <= '{out: 1'b1, count: `CCF_RST_RELOAD, reload: `CCF_RST_RELOAD};
            end
        end else begin
            clk_prev <= clk_lvl;
            for (int i = 0; i < 12; i++) begin
                if (dp_write && dp_addr == 8'(`CCF_OFS_RELOAD + 4 * i)) begin
                    // a new reload restarts the count with output high
                    ctr[i] <= '{out: 1'b1, count: hwdata[15:0], reload: hwdata[15:0]};
                end else if (clk_edge[i] && gate[i]) begin
                    ctr[i] <= ctr_step(ctr[i], mode[i]);
                end
            end
        end
    end

    // outputs straight to pins and onward into the routing
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            counter_output[i] = ctr[i].out;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    assign irq_event[0] = counter_output[11] & ~c12_prev;
    assign irq_event[1] = filt[10] & ~ext_int_prev;

    // sticky pending; set beats a same-cycle clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            c12_prev <= 1'b1; // output idles high, so no false event
            ext_int_prev <= 1'b0;
            irq_pend <= 2'h0;
            inta_n <= 1'b1;
        end else begin
            c12_prev <= counter_output[11];
            ext_int_prev <= filt[10];
            for (int k = 0; k < 2; k++) begin
                if (irq_en[k] && irq_event[k]) begin
                    irq_pend[k] <= 1'b1;
                end else if (dp_write && dp_addr == `CCF_OFS_IRQ
                             && hwdata[`CCF_IRQ_PEND_LSB + k]) begin
                    irq_pend[k] <= 1'b0;
                end
            end
            inta_n <= ~|(irq_pend & irq_en);
        end
    end

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    assign ap_take = hsel && htrans[1] && hready;

    // read word picked in the address phase so hrdata leaves a flop
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (haddr[7:0] < 8'(`CCF_OFS_RELOAD + 48) && haddr[31:8] == 24'h00_0000) begin
            next_rdata = {16'h0000, ctr[haddr[5:2]].count};
        end else if (haddr[31:8] == 24'h00_0000) begin
            case (haddr[7:0])
                `CCF_OFS_CLKSEL: next_rdata = {11'h000, clk_sel};
                `CCF_OFS_MODE: next_rdata = {20'h0_0000, mode};
                `CCF_OFS_DEBOUNCE: next_rdata = {21'h00_0000, db_en};
                `CCF_OFS_IRQ: next_rdata = {22'h00_0000, irq_pend, 6'h00, irq_en};
                `CCF_OFS_STATUS: next_rdata = {4'h0, gate, 4'h0, counter_output};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // zero-wait slave, always OKAY; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_addr <= 8'h00;
            dp_write <= 1'b0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            dp_write <= ap_take && hwrite && haddr[31:8] == 24'h00_0000;
            dp_addr <= haddr[7:0];
            if (ap_take && !hwrite) begin
                hrdata <= next_rdata;
            end
        end
    end

    // control registers written in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_sel <= `CCF_RST_CLKSEL;
            mode <= `CCF_RST_MODE;
            db_en <= `CCF_RST_DEBOUNCE;
            irq_en <= `CCF_RST_IRQ_EN;
        end else if (dp_write) begin
            case (dp_addr)
                `CCF_OFS_CLKSEL: clk_sel <= hwdata[20:0];
                `CCF_OFS_MODE: mode <= hwdata[11:0];
                `CCF_OFS_DEBOUNCE: db_en <= hwdata[10:0];
                `CCF_OFS_IRQ: irq_en <= hwdata[`CCF_IRQ_EN_LSB +: 2];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_db_change;
        db_strobe && db_raw[10] != db_out[10] && db_cnt[10] == 2'h3;
    endsequence

    sequence s_db_short;
        db_strobe && db_raw[10] != db_out[10] && db_cnt[10] != 2'h3;
    endsequence

    // line drops one edge after pending, unless software masked it meanwhile
    sequence s_c12_raise;
        irq_pend[0] ##1 (!inta_n || !$past(irq_en[0]));
    endsequence

    sequence s_sq_wrap;
        clk_edge[11] && !mode[11] && ctr[11].count == 16'h0001 && !dp_write;
    endsequence

    a_c12_from_c11: assert property (clk_lvl[11] == counter_output[10])
        else $error("counter 12 clock not taken from counter 11");
    a_ctr1_ground: assert property (clk_sel[1:0] == 2'h1 |-> !clk_lvl[0])
        else $error("counter 1 clock not grounded in cascade");
    a_shared_fixed: assert property (!clk_sel[20] |-> shared_clk == fixed_lvl)
        else $error("shared clock not fixed source");
    a_db_change_out: assert property (s_db_change |=> db_out[10] == $past(db_raw[10]))
        else $error("debounce did not follow stable input");
    a_db_hold_out: assert property (s_db_short |=> $stable(db_out[10]))
        else $error("debounce followed short excursion");
    a_irq_c12_set: assert property (irq_en[0] && irq_event[0] |=> s_c12_raise)
        else $error("counter 12 interrupt not raised");
    a_irq_ext_set: assert property (irq_en[1] && irq_event[1] |=> irq_pend[1])
        else $error("external interrupt not raised");
    a_irq_masked: assert property (!irq_en[1] && !irq_pend[1] |=> !irq_pend[1])
        else $error("disabled source became pending");
    a_inta_merge: assert property (##1 inta_n == !$past(|(irq_pend & irq_en)))
        else $error("shared request line wrong");
    a_sq_toggle: assert property (s_sq_wrap |=> $changed(counter_output[11]))
        else $error("square output failed to toggle");
    a_gate_fixed: assert property (gate[11:10] == 2'b11)
        else $error("cascade gates not high");
endmodule

// ==== ccf_field_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// field side: external clocks, gates, interrupt, sample clock
// ------------------------------------------------------------
module ccf_field_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [9:0] clk_on,
    input wire logic [9:0] gate_req,
    input wire logic int_req,
    input wire logic db_on,
    output logic [9:0] external_counter_clock,
    output logic [9:0] gate_in,
    output logic external_interrupt_input,
    output logic debounce_sample_clock
);
    logic [1:0] ext_div;
    logic [3:0] db_div;

    // external clocks of 8 hclk period, parked low when off so no stray edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_div <= 2'h0;
            external_counter_clock <= 10'h000;
        end else begin
            ext_div <= ext_div + 2'h1;
            if (ext_div == 2'h3) begin
                external_counter_clock <= ~external_counter_clock & clk_on;
            end else begin
                external_counter_clock <= external_counter_clock & clk_on;
            end
        end
    end

    // sample clock of 20 hclk period, i.e. 2 MHz, never faster
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            db_div <= 4'h0;
            debounce_sample_clock <= 1'b0;
        end else if (!db_on) begin
            db_div <= 4'h0;
            debounce_sample_clock <= 1'b0;
        end else begin
            db_div <= (db_div == 4'h9) ? 4'h0 : db_div + 4'h1;
            if (db_div == 4'h9) begin
                debounce_sample_clock <= ~debounce_sample_clock;
            end
        end
    end

    // gates and interrupt follow the bench's requests as plain levels
    assign gate_in = gate_req;
    assign external_interrupt_input = int_req;
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
`include "ccf_cfg.svh"
module tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, inta_n;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [11:0] counter_output;
    logic [9:0] external_counter_clock, gate_in, clk_on, gate_req;
    logic external_interrupt_input, debounce_sample_clock, int_req, db_on;
    int err_count, tests_run;
    int ci[8] = '{0, 1, 2, 3, 4, 9, 10, 11};
    int pe[8] = '{32, 128, 30, 80, 24, 20, 20, 80};
    int ci2[3] = '{2, 9, 3};
    int pe2[3] = '{120, 80, 320};
    logic [7:0] ra[5];

    ccf_fabric dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .external_counter_clock(external_counter_clock), .gate_in(gate_in),
        .external_interrupt_input(external_interrupt_input),
        .debounce_sample_clock(debounce_sample_clock),
        .counter_output(counter_output), .inta_n(inta_n));

    ccf_field_model field (.hclk(hclk), .hresetn(hresetn), .clk_on(clk_on),
        .gate_req(gate_req), .int_req(int_req), .db_on(db_on),
        .external_counter_clock(external_counter_clock), .gate_in(gate_in),
        .external_interrupt_input(external_interrupt_input),
        .debounce_sample_clock(debounce_sample_clock));

    // ------------------------------------------------------------
    // clock, checks and bus access
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one single transfer; read data lands in rd at the data-phase edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk({31'h0000_0000, hresp}, 32'h0000_0000);
    endtask

    // sampled on the falling edge so flop updates have settled
    task automatic wait_out(input int i, input logic v, output int n);
        n = 0;
        while (counter_output[i] !== v && n < 4000) begin
            @(negedge hclk);
            n++;
        end
    endtask

    // rise-to-rise period of one counter output, in hclk cycles
    task automatic per(input int i, input int e);
        int a;
        int b;
        @(negedge hclk);
        wait_out(i, 1'b0, a);
        wait_out(i, 1'b1, a);
        wait_out(i, 1'b0, a);
        wait_out(i, 1'b1, b);
        chk(a + b, e);
    endtask

    task automatic print_verdict();
        $display("mismatches %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog: the whole sequence needs well under 20k cycles
    // ------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge hclk);
        err_count++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        clk_on = 10'h000;
        gate_req = 10'h3FF;
        int_req = 1'b0;
        db_on = 1'b0;
        err_count = 0;
        tests_run = 0;
        ra = '{`CCF_OFS_CLKSEL, `CCF_OFS_MODE, `CCF_OFS_DEBOUNCE, `CCF_OFS_IRQ, 8'h44};
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({20'h0_0000, counter_output}, 32'h0000_0FFF);
        chk({31'h0000_0000, inta_n}, 32'h0000_0001);
        // control registers clear, unmapped place reads zero even after a write
        bus(1'b1, 8'h44, 32'hFFFF_FFFF);
        foreach (ra[k]) begin
            bus(1'b0, ra[k], 32'h0000_0000);
            chk(rd, 32'h0000_0000);
        end
        // every source kind, rate mode on counter 5, fixed chain 11 to 12
        bus(1'b1, `CCF_OFS_CLKSEL, 32'h0008_00E4);
        bus(1'b1, `CCF_OFS_MODE, 32'h0000_0010);
        bus(1'b1, 8'h00, 32'h0000_0002);
        bus(1'b1, 8'h04, 32'h0000_0002);
        bus(1'b1, 8'h08, 32'h0000_0003);
        bus(1'b1, 8'h0C, 32'h0000_0002);
        bus(1'b1, 8'h10, 32'h0000_0003);
        bus(1'b1, 8'h24, 32'h0000_0002);
        bus(1'b1, 8'h28, 32'h0000_0002);
        bus(1'b1, 8'h2C, 32'h0000_0002);
        clk_on <= 10'h011;
        foreach (ci[k]) per(ci[k], pe[k]);
        // shared clock now from counter 11
        bus(1'b1, `CCF_OFS_CLKSEL, 32'h0018_00E4);
        foreach (ci2[k]) per(ci2[k], pe2[k]);
        // counter 1 on the previous counter sees a grounded clock
        bus(1'b1, `CCF_OFS_CLKSEL, 32'h0018_00E5);
        bus(1'b1, 8'h00, 32'h0000_0004);
        repeat (200) @(posedge hclk);
        bus(1'b0, 8'h00, 32'h0000_0000);
        chk(rd & 32'h0000_FFFF, 32'h0000_0004);
        // a low gate freezes counter 5 although its clock keeps running
        gate_req <= 10'h3EF;
        bus(1'b1, 8'h10, 32'h0000_0003);
        repeat (200) @(posedge hclk);
        bus(1'b0, 8'h10, 32'h0000_0000);
        chk(rd & 32'h0000_FFFF, 32'h0000_0003);
        bus(1'b0, `CCF_OFS_STATUS, 32'h0000_0000);
        chk(rd & 32'h0FFF_0000, 32'h0FEF_0000);
        gate_req <= 10'h3FF;
        // external source alone, then both pending together
        bus(1'b1, `CCF_OFS_IRQ, 32'h0000_0002);
        int_req <= 1'b1;
        repeat (10) @(posedge hclk);
        bus(1'b0, `CCF_OFS_IRQ, 32'h0000_0000);
        chk(rd & 32'h0000_0300, 32'h0000_0200);
        chk({31'h0000_0000, inta_n}, 32'h0000_0000);
        bus(1'b1, `CCF_OFS_IRQ, 32'h0000_0003);
        repeat (200) @(posedge hclk);
        bus(1'b0, `CCF_OFS_IRQ, 32'h0000_0000);
        chk(rd & 32'h0000_0300, 32'h0000_0300);
        // disable, clear, and a disabled source stays quiet
        bus(1'b1, `CCF_OFS_IRQ, 32'h0000_0000);
        bus(1'b1, `CCF_OFS_IRQ, 32'h0000_0300);
        int_req <= 1'b0;
        repeat (10) @(posedge hclk);
        int_req <= 1'b1;
        repeat (20) @(posedge hclk);
        bus(1'b0, `CCF_OFS_IRQ, 32'h0000_0000);
        chk(rd & 32'h0000_0300, 32'h0000_0000);
        chk({31'h0000_0000, inta_n}, 32'h0000_0001);
        int_req <= 1'b0;
        // filtered interrupt: a two-sample pulse is dropped, a long one passes
        bus(1'b1, `CCF_OFS_DEBOUNCE, 32'h0000_0400);
        db_on <= 1'b1;
        bus(1'b1, `CCF_OFS_IRQ, 32'h0000_0002);
        repeat (100) @(posedge hclk);
        int_req <= 1'b1;
        repeat (40) @(posedge hclk);
        int_req <= 1'b0;
        repeat (200) @(posedge hclk);
        bus(1'b0, `CCF_OFS_IRQ, 32'h0000_0000);
        chk(rd & 32'h0000_0300, 32'h0000_0000);
        int_req <= 1'b1;
        repeat (200) @(posedge hclk);
        bus(1'b0, `CCF_OFS_IRQ, 32'h0000_0000);
        chk(rd & 32'h0000_0300, 32'h0000_0200);
        print_verdict();
    end
endmodule
